/* rtcc_pkg.sv */
package rtcc_pkg;

    // Timing: 128 Hz drives the first stage of the divider chain
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned STAGE_PERIOD_NS = 7_812_500;
    localparam int unsigned STAGE_CYCLES = STAGE_PERIOD_NS / CLK_PERIOD_NS;

    // APB geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DIV = 8'hC0;
    localparam logic [7:0] IDX_SEC = 8'hC2;
    localparam logic [7:0] IDX_MIN = 8'hC4;
    localparam logic [7:0] IDX_HR = 8'hC6;
    localparam logic [7:0] IDX_WK = 8'hC8;
    localparam logic [7:0] IDX_DATE = 8'hCA;
    localparam logic [7:0] IDX_MON = 8'hCC;
    localparam logic [7:0] IDX_YEAR = 8'hCE;
    localparam logic [7:0] IDX_SEC_ALARM = 8'hD0;
    localparam logic [7:0] IDX_CTRL = 8'hE0;
    localparam logic [7:0] IDX_STATUS = 8'hE2;

    // Field masks: write masks, and DIV_MASK for divider reads
    localparam logic [7:0] DIV_MASK = 8'h7F;
    localparam logic [7:0] SEC_MASK = 8'h7F;
    localparam logic [7:0] MIN_MASK = 8'h7F;
    localparam logic [7:0] HR_MASK = 8'h3F;
    localparam logic [7:0] WK_MASK = 8'h07;
    localparam logic [7:0] DATE_MASK = 8'h3F;
    localparam logic [7:0] MON_MASK = 8'h1F;
    localparam logic [7:0] YEAR_MASK = 8'hFF;
    localparam int unsigned ALARM_EN_BIT = 7;

    // BCD limits
    localparam logic [7:0] ZERO = 8'h00;
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HR_MAX = 8'h23;
    localparam logic [7:0] WK_MAX = 8'h06;
    localparam logic [7:0] DATE_MIN = 8'h01;
    localparam logic [7:0] MON_MIN = 8'h01;
    localparam logic [7:0] MON_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] ADJUST_HALF = 8'h30;
    localparam logic [7:0] FEB = 8'h02;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [6:0] DIV_FULL = 7'h7F;

    // Control and status bits
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_DIVRST_BIT = 1;
    localparam int unsigned CTRL_ADJUST_BIT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam int unsigned STAT_CARRY_BIT = 0;
    localparam int unsigned STAT_ALARM_BIT = 1;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] mon;
        logic [7:0] date;
        logic [7:0] wk;
        logic [7:0] hr;
        logic [7:0] min;
        logic [7:0] sec;
    } rtcc_time_t;

endpackage

/* rtcc_calendar.sv */
// Functional notes
// - Divider status shows 64Hz to 1Hz stages
// - Divider reset or adjust clears divider
// - Divider status bit 7 reads zero
// - Divider and counters ignore power-on reset
// - Seconds BCD, advance on 1Hz carry
// - Minutes BCD 00-59, advance on seconds carry
// - Hours BCD 00-23, advance on minutes carry
// - Weekday 0-6, advances on daily carry
// - Weekday code 0 Sunday to 6 Saturday
// - Date BCD 01-31, advances daily
// - Month BCD, advances on date carry
// - Year two BCD digits, advances yearly
// - Leap year when year divisible by four
// - Second alarm compares when enable set
// - Alarm only when all enabled compares match
// - Power-on reset clears alarm enable and status flags, sets start
// - Carry flag set on divider/seconds count
module rtcc_calendar #(
    parameter int unsigned STAGE_CYCLES = rtcc_pkg::STAGE_CYCLES
) (
    input wire logic pclk, // APB clock, 10 MHz
    input wire logic presetn, // Power-on reset, async, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [rtcc_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [rtcc_pkg::DATA_W-1:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [rtcc_pkg::DATA_W-1:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    input wire logic other_alarm_enabled, // Some other alarm field enabled
    input wire logic other_alarm_match, // All enabled other fields match
    output logic alarm_event, // One-cycle alarm pulse
    output logic second_tick, // One-cycle pulse per seconds count
    output rtcc_pkg::rtcc_time_t time_now // Calendar state
);

    logic [$clog2(STAGE_CYCLES)-1:0] presc_q;
    logic [6:0] div_q;
    rtcc_pkg::rtcc_time_t cal_q;
    logic [6:0] alarm_sec_q;
    logic alarm_en_q;
    logic [7:0] ctrl_q;
    logic carry_flag_q;
    logic alarm_flag_q;
    logic match_q;
    logic alarm_event_q;
    logic second_tick_q;
    logic [7:0] rd_data_q;
    logic hit_q;

    logic setup;
    logic wr_acc;
    logic [7:0] wbyte;
    logic [7:0] rd_data;
    logic rd_hit;
    logic started;
    logic stage_tick;
    logic div_carry;
    logic div_clear;
    logic adjust_carry;
    logic sec_carry;
    logic min_carry;
    logic hr_carry;
    logic day_carry;
    logic mon_carry;
    logic leap;
    logic [7:0] last_day;
    logic match_d;
    logic wr_div_clear;

    function automatic logic [rtcc_pkg::ADDR_W-1:0] addr_of(input logic [7:0] idx);
        return rtcc_pkg::ADDR_W'({idx, 2'b00});
    endfunction

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] bottom);
        logic [7:0] r;
        r = v;
        if (v == top)
        begin
            r = bottom;
        end
        else if (v[3:0] == 4'h9)
        begin
            r = {v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    function automatic logic wr_to(input logic [7:0] idx, input logic acc,
                                   input logic [rtcc_pkg::ADDR_W-1:0] a);
        return acc && (a == addr_of(idx));
    endfunction

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];
    assign started = ctrl_q[rtcc_pkg::CTRL_START_BIT];

    // Divider reset and adjust are one-shot actions on a control write
    assign wr_div_clear = wr_to(rtcc_pkg::IDX_CTRL, wr_acc, paddr)
                          && (wbyte[rtcc_pkg::CTRL_DIVRST_BIT] || wbyte[rtcc_pkg::CTRL_ADJUST_BIT]);
    assign div_clear = wr_div_clear;
    assign adjust_carry = wr_to(rtcc_pkg::IDX_CTRL, wr_acc, paddr) && wbyte[rtcc_pkg::CTRL_ADJUST_BIT]
                          && (cal_q.sec >= rtcc_pkg::ADJUST_HALF);

    // Carry chain
    assign stage_tick = started && (presc_q == ($clog2(STAGE_CYCLES))'(STAGE_CYCLES - 1)) && !div_clear;
    assign div_carry = stage_tick && (div_q == rtcc_pkg::DIV_FULL);
    assign sec_carry = (div_carry && (cal_q.sec == rtcc_pkg::SEC_MAX)) || adjust_carry;
    assign min_carry = sec_carry && (cal_q.min == rtcc_pkg::SEC_MAX);
    assign hr_carry = min_carry && (cal_q.hr == rtcc_pkg::HR_MAX);
    assign day_carry = hr_carry && (cal_q.date == last_day);
    assign mon_carry = day_carry && (cal_q.mon == rtcc_pkg::MON_MAX);

    // Two-digit year only: century years all count as leap
    always_comb
    begin
        if (!cal_q.year[4])
        begin
            leap = (cal_q.year[3:0] == 4'h0) || (cal_q.year[3:0] == 4'h4) || (cal_q.year[3:0] == 4'h8);
        end
        else
        begin
            leap = (cal_q.year[3:0] == 4'h2) || (cal_q.year[3:0] == 4'h6);
        end
    end

    always_comb
    begin
        case (cal_q.mon)
            rtcc_pkg::FEB: last_day = leap ? rtcc_pkg::DAYS_29 : rtcc_pkg::DAYS_28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = rtcc_pkg::DAYS_30;
            default: last_day = rtcc_pkg::DAYS_31;
        endcase
    end

    // Prescaler stands in for the oscillator front end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= '0;
        end
        else if (div_clear || stage_tick)
        begin
            presc_q <= '0;
        end
        else if (started)
        begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // No power-on reset: time must survive presetn
    always_ff @(posedge pclk)
    begin
        if (div_clear)
        begin
            div_q <= '0;
        end
        else if (stage_tick)
        begin
            div_q <= div_q + 7'h01;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_CTRL, wr_acc, paddr) && wbyte[rtcc_pkg::CTRL_ADJUST_BIT])
        begin
            cal_q.sec <= rtcc_pkg::ZERO;
        end
        else if (wr_to(rtcc_pkg::IDX_SEC, wr_acc, paddr))
        begin
            cal_q.sec <= wbyte & rtcc_pkg::SEC_MASK;
        end
        else if (div_carry)
        begin
            cal_q.sec <= bcd_inc(cal_q.sec, rtcc_pkg::SEC_MAX, rtcc_pkg::ZERO);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_MIN, wr_acc, paddr))
        begin
            cal_q.min <= wbyte & rtcc_pkg::MIN_MASK;
        end
        else if (sec_carry)
        begin
            cal_q.min <= bcd_inc(cal_q.min, rtcc_pkg::SEC_MAX, rtcc_pkg::ZERO);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_HR, wr_acc, paddr))
        begin
            cal_q.hr <= wbyte & rtcc_pkg::HR_MASK;
        end
        else if (min_carry)
        begin
            cal_q.hr <= bcd_inc(cal_q.hr, rtcc_pkg::HR_MAX, rtcc_pkg::ZERO);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_WK, wr_acc, paddr))
        begin
            cal_q.wk <= wbyte & rtcc_pkg::WK_MASK;
        end
        else if (hr_carry)
        begin
            cal_q.wk <= bcd_inc(cal_q.wk, rtcc_pkg::WK_MAX, rtcc_pkg::ZERO);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_DATE, wr_acc, paddr))
        begin
            cal_q.date <= wbyte & rtcc_pkg::DATE_MASK;
        end
        else if (hr_carry)
        begin
            cal_q.date <= bcd_inc(cal_q.date, last_day, rtcc_pkg::DATE_MIN);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_MON, wr_acc, paddr))
        begin
            cal_q.mon <= wbyte & rtcc_pkg::MON_MASK;
        end
        else if (day_carry)
        begin
            cal_q.mon <= bcd_inc(cal_q.mon, rtcc_pkg::MON_MAX, rtcc_pkg::MON_MIN);
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_YEAR, wr_acc, paddr))
        begin
            cal_q.year <= wbyte & rtcc_pkg::YEAR_MASK;
        end
        else if (mon_carry)
        begin
            cal_q.year <= bcd_inc(cal_q.year, rtcc_pkg::YEAR_MAX, rtcc_pkg::ZERO);
        end
    end

    // Alarm enable sees power-on reset; alarm seconds do not
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_en_q <= 1'b0;
        end
        else if (wr_to(rtcc_pkg::IDX_SEC_ALARM, wr_acc, paddr))
        begin
            alarm_en_q <= wbyte[rtcc_pkg::ALARM_EN_BIT];
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_to(rtcc_pkg::IDX_SEC_ALARM, wr_acc, paddr))
        begin
            alarm_sec_q <= wbyte[6:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= rtcc_pkg::CTRL_RESET;
        end
        else if (wr_to(rtcc_pkg::IDX_CTRL, wr_acc, paddr))
        begin
            ctrl_q <= {7'h00, wbyte[rtcc_pkg::CTRL_START_BIT]};
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carry_flag_q <= 1'b0;
        end
        else if (stage_tick || div_carry)
        begin
            carry_flag_q <= 1'b1;
        end
        else if (wr_to(rtcc_pkg::IDX_STATUS, wr_acc, paddr) && !wbyte[rtcc_pkg::STAT_CARRY_BIT])
        begin
            carry_flag_q <= 1'b0;
        end
    end

    // Disabled fields are ignored; at least one field must be enabled
    always_comb
    begin
        match_d = (alarm_en_q || other_alarm_enabled) && other_alarm_match
                  && (!alarm_en_q || (cal_q.sec[6:0] == alarm_sec_q));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_q <= 1'b0;
            alarm_event_q <= 1'b0;
            second_tick_q <= 1'b0;
        end
        else
        begin
            match_q <= match_d;
            alarm_event_q <= match_d && !match_q;
            second_tick_q <= div_carry;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_flag_q <= 1'b0;
        end
        else if (match_d && !match_q)
        begin
            alarm_flag_q <= 1'b1;
        end
        else if (wr_to(rtcc_pkg::IDX_STATUS, wr_acc, paddr) && !wbyte[rtcc_pkg::STAT_ALARM_BIT])
        begin
            alarm_flag_q <= 1'b0;
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        rd_data = rtcc_pkg::ZERO;
        case (paddr)
            addr_of(rtcc_pkg::IDX_DIV): rd_data = {1'b0, div_q} & rtcc_pkg::DIV_MASK;
            addr_of(rtcc_pkg::IDX_SEC): rd_data = cal_q.sec;
            addr_of(rtcc_pkg::IDX_MIN): rd_data = cal_q.min;
            addr_of(rtcc_pkg::IDX_HR): rd_data = cal_q.hr;
            addr_of(rtcc_pkg::IDX_WK): rd_data = cal_q.wk;
            addr_of(rtcc_pkg::IDX_DATE): rd_data = cal_q.date;
            addr_of(rtcc_pkg::IDX_MON): rd_data = cal_q.mon;
            addr_of(rtcc_pkg::IDX_YEAR): rd_data = cal_q.year;
            addr_of(rtcc_pkg::IDX_SEC_ALARM): rd_data = {alarm_en_q, alarm_sec_q};
            addr_of(rtcc_pkg::IDX_CTRL): rd_data = ctrl_q;
            addr_of(rtcc_pkg::IDX_STATUS): rd_data = {6'h00, alarm_flag_q, carry_flag_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read data captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data_q <= rtcc_pkg::ZERO;
            hit_q <= 1'b0;
        end
        else if (setup)
        begin
            rd_data_q <= rd_data;
            hit_q <= rd_hit;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_q;
    assign prdata = {24'h00_0000, rd_data_q};
    assign alarm_event = alarm_event_q;
    assign second_tick = second_tick_q;
    assign time_now = cal_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_div_clear_write;
        wr_div_clear;
    endsequence

    sequence s_div_read_setup;
        setup && (paddr == addr_of(rtcc_pkg::IDX_DIV));
    endsequence

    AST_DIV_CLEAR: assert property (s_div_clear_write |=> (div_q == 7'h00) && (presc_q == '0))
        else $error("divider not cleared by control write");

    AST_DIV_MSB: assert property (s_div_read_setup |=> (prdata[7] == 1'b0))
        else $error("divider status bit 7 not zero");

    AST_DIV_STEP: assert property (stage_tick |=> (div_q == $past(div_q) + 7'h01))
        else $error("divider did not step on stage tick");

    AST_SEC_STEP: assert property (div_carry && (cal_q.sec != rtcc_pkg::SEC_MAX) && !wr_acc
                                   |=> (cal_q.sec != $past(cal_q.sec)) && !min_carry)
        else $error("seconds did not advance on 1Hz carry");

    AST_MIN_WRAP: assert property (sec_carry && (cal_q.min == rtcc_pkg::SEC_MAX) && !wr_acc
                                   |=> (cal_q.min == rtcc_pkg::ZERO))
        else $error("minutes did not wrap to zero");

    AST_HR_WRAP: assert property (min_carry && (cal_q.hr == rtcc_pkg::HR_MAX) && !wr_acc
                                  |=> (cal_q.hr == rtcc_pkg::ZERO) && (cal_q.wk != $past(cal_q.wk)))
        else $error("hours did not wrap with daily carry");

    AST_WK_WRAP: assert property (hr_carry && (cal_q.wk == rtcc_pkg::WK_MAX) && !wr_acc
                                  |=> (cal_q.wk == rtcc_pkg::ZERO))
        else $error("weekday did not wrap from 6 to 0");

    AST_LEAP_FEB: assert property (hr_carry && leap && (cal_q.mon == rtcc_pkg::FEB)
                                   && (cal_q.date == rtcc_pkg::DAYS_28) && !wr_acc
                                   |=> (cal_q.date == rtcc_pkg::DAYS_29))
        else $error("leap February skipped the 29th");

    AST_DATE_WRAP: assert property (day_carry && !wr_acc |=> (cal_q.date == rtcc_pkg::DATE_MIN))
        else $error("date did not return to 01");

    AST_ALARM: assert property (alarm_event |-> $past(match_d) && !$past(match_q)
                                && ($past(alarm_en_q) == 1'b0 || $past(cal_q.sec[6:0]) == $past(alarm_sec_q)))
        else $error("alarm pulse without full match");

    AST_CARRY_FLAG: assert property (stage_tick |=> carry_flag_q ##1 (carry_flag_q || $past(wr_acc)))
        else $error("carry flag not set on count");

endmodule

/* rtc_calendar_counters_test.sv */
module rtc_calendar_counters_test;
    timeunit 1ns;
    timeprecision 1ns;

    // Short prescaler keeps one second at 512 cycles
    localparam int unsigned STAGE = 4;
    localparam logic [7:0] TIDX [7] = '{rtcc_pkg::IDX_YEAR, rtcc_pkg::IDX_MON, rtcc_pkg::IDX_DATE,
        rtcc_pkg::IDX_WK, rtcc_pkg::IDX_HR, rtcc_pkg::IDX_MIN, rtcc_pkg::IDX_SEC};
    localparam rtcc_pkg::rtcc_time_t ROLL_IN [7] = '{56'h99_1231_0623_5959, 56'h04_0228_0323_5959,
        56'h04_0229_0423_5959, 56'h05_0228_0523_5959, 56'h05_0430_0123_5959, 56'h05_0131_0223_5959,
        56'h00_0228_0523_5959};
    localparam rtcc_pkg::rtcc_time_t ROLL_EXP [7] = '{56'h00_0101_0000_0000, 56'h04_0229_0400_0000,
        56'h04_0301_0500_0000, 56'h05_0301_0600_0000, 56'h05_0501_0200_0000, 56'h05_0201_0300_0000,
        56'h00_0229_0600_0000};

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [rtcc_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [rtcc_pkg::DATA_W-1:0] pwdata = 32'h0000_0000;
    logic pready;
    logic [rtcc_pkg::DATA_W-1:0] prdata;
    logic pslverr;
    logic other_alarm_enabled = 1'b0;
    logic other_alarm_match = 1'b1;
    logic alarm_event;
    logic second_tick;
    rtcc_pkg::rtcc_time_t time_now;
    int error_cnt = 0;
    int check_count = 0;
    int alarm_cnt = 0;

    rtcc_calendar #(.STAGE_CYCLES(STAGE)) dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .other_alarm_enabled(other_alarm_enabled),
        .other_alarm_match(other_alarm_match),
        .alarm_event(alarm_event),
        .second_tick(second_tick),
        .time_now(time_now)
    );

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (alarm_event === 1'b1)
            alarm_cnt <= alarm_cnt + 1;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic note(input string name);
        $display("test %s done", name);
    endtask

    function automatic logic [11:0] addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // Entry waits an edge so back-to-back calls never reassign in one step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            error_cnt++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(addr(idx), 1'b1, {24'h00_0000, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] r);
        logic e;
        apb(addr(idx), 1'b0, 32'h0000_0000, r, e);
    endtask

    task automatic wait_tick;
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (second_tick !== 1'b1 && n < 1000);
        if (n >= 1000)
            error_cnt++;
        @(posedge pclk);
        chk(second_tick, 1'b0);
    endtask

    // Counting stopped and divider cleared before the counters are loaded
    task automatic set_time(input rtcc_pkg::rtcc_time_t t);
        logic [31:0] r;
        wr(rtcc_pkg::IDX_CTRL, 8'h02);
        for (int i = 0; i < 7; i++)
            wr(TIDX[i], t[8*(6-i) +: 8]);
        for (int i = 0; i < 7; i++)
        begin
            rd(TIDX[i], r);
            chk(r, {24'h00_0000, t[8*(6-i) +: 8]});
        end
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        end_sim;
    end

    initial
    begin
        logic [31:0] r;
        logic e;
        int base;
        rtcc_pkg::rtcc_time_t snap;
        repeat (5) @(posedge pclk);
        chk({pready, prdata, second_tick, alarm_event}, {1'b1, 32'h0000_0000, 2'b00});
        presetn <= 1'b1;
        // Divider powers up unknown: clear it before its first stage tick
        wr(rtcc_pkg::IDX_CTRL, 8'h03);
        rd(rtcc_pkg::IDX_CTRL, r);
        chk(r, 32'h0000_0001);
        rd(rtcc_pkg::IDX_SEC_ALARM, r);
        chk(r[7], 1'b0);
        note("reset");

        wr(rtcc_pkg::IDX_CTRL, 8'h02);
        rd(rtcc_pkg::IDX_DIV, r);
        chk(r, 32'h0000_0000);
        wr(rtcc_pkg::IDX_DIV, 8'hD5);
        rd(rtcc_pkg::IDX_DIV, r);
        chk(r, 32'h0000_0000);
        apb(12'h3FC, 1'b1, 32'h0000_005A, r, e);
        chk(e, 1'b1);
        apb(12'h3FC, 1'b0, 32'h0000_0000, r, e);
        chk({e, r}, {1'b1, 32'h0000_0000});
        apb(addr(rtcc_pkg::IDX_SEC), 1'b0, 32'h0000_0000, r, e);
        chk(e, 1'b0);
        note("access");

        set_time(56'h05_0101_0000_0000);
        wr(rtcc_pkg::IDX_STATUS, 8'h00);
        rd(rtcc_pkg::IDX_STATUS, r);
        chk(r[0], 1'b0);
        wr(rtcc_pkg::IDX_CTRL, 8'h01);
        repeat (12) @(posedge pclk);
        rd(rtcc_pkg::IDX_STATUS, r);
        chk(r[0], 1'b1);
        note("carry");

        for (int i = 0; i < 7; i++)
        begin
            set_time(ROLL_IN[i]);
            wr(rtcc_pkg::IDX_CTRL, 8'h01);
            wait_tick;
            chk(time_now, ROLL_EXP[i]);
            note("rollover");
        end

        // Bit 6 is the 1 Hz stage: low just after a second, high past half
        rd(rtcc_pkg::IDX_DIV, r);
        chk(r[7:6], 2'b00);
        repeat (256) @(posedge pclk);
        rd(rtcc_pkg::IDX_DIV, r);
        chk(r[7:6], 2'b01);
        note("divider");

        for (int k = 0; k < 2; k++)
        begin
            set_time({40'h05_0101_0010, 8'h20, (k == 1) ? 8'h45 : 8'h15});
            wr(rtcc_pkg::IDX_CTRL, 8'h05);
            repeat (2) @(posedge pclk);
            chk(time_now[15:0], (k == 1) ? 16'h2100 : 16'h2000);
            rd(rtcc_pkg::IDX_DIV, r);
            chk(r[7:3], 5'h00);
        end
        note("adjust");

        set_time(56'h05_0101_0000_0003);
        wr(rtcc_pkg::IDX_SEC_ALARM, 8'h85);
        wr(rtcc_pkg::IDX_STATUS, 8'h00);
        other_alarm_enabled <= 1'b1;
        other_alarm_match <= 1'b0;
        base = alarm_cnt;
        wr(rtcc_pkg::IDX_CTRL, 8'h01);
        wait_tick;
        wait_tick;
        repeat (20) @(posedge pclk);
        chk(alarm_cnt - base, 0);
        other_alarm_match <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(alarm_cnt - base, 1);
        chk(time_now.sec, 8'h05);
        rd(rtcc_pkg::IDX_STATUS, r);
        chk(r[1], 1'b1);
        other_alarm_enabled <= 1'b0;
        wr(rtcc_pkg::IDX_SEC_ALARM, 8'h06);
        wait_tick;
        repeat (5) @(posedge pclk);
        chk(alarm_cnt - base, 1);
        note("alarm");

        // Reset in mid-run must leave the calendar and alarm field alone
        wr(rtcc_pkg::IDX_SEC_ALARM, 8'h86);
        wait_tick;
        snap = time_now;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(time_now, snap);
        rd(rtcc_pkg::IDX_SEC_ALARM, r);
        chk(r, 32'h0000_0006);
        note("retention");
        end_sim;
    end
endmodule
